// ### rtl/asu_port.sv
// Asynchronous serial transceiver with register port and two queues.
// Assumes a single 100 MHz clock; line input arrives asynchronously.
//
// Summary of operation
// (RL1) Bytes become serial frames and back
// (RL2) Receive queue 16x12, transmit queue 16x8
// (RL3) Start, parity, stop added and stripped
// (RL4) Five to eight data bits
// (RL5) Even, odd, stick or no parity
// (RL6) One or two stop bits sent
// (RL7) Baud divider up to clock over sixteen
// (RL8) Break sent and break detected
// (RL9) Break control holds line low when infrared is off
// (RL10) Infrared encoder and decoder selectable
// (RL11) Busy while queued or shifting
// (RL12) Busy ends after last stop bit
// (RL13) Data read pops oldest received character
// (RL14) Stick parity forced and checked constant
// (RL15) Flag shows receive queue not empty
// (RL16) Flag shows transmit room; full writes dropped
// (RL17) Clearing both port and transmit enables finishes character, then flushes queue
// (RL18) Entry holds data plus four error bits
// (RL19) Sixteen-fold sampling, mid-bit start check
`timescale 1ns/100ps
module asu_port
	import asu_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_rx,
	output logic o_tx,
	output logic o_busy
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [`ASU_CTL_W-1:0] ctl_q;
	asu_fmt_t fmt_q;
	logic [15:0] baud_q;
	logic [31:0] rdata_q;
	logic tx_in_ready, tx_out_valid, tx_pop, rx_push, rx_in_ready, rx_out_valid, rx_pop;
	logic [7:0] tx_out_data;
	asu_rx_word_t rx_out_data, rx_word_d;
	logic tx_active, flush_q;
	logic port_enable, transmit_enable, receive_enable, infrared_enable;
	logic infrared_low_power, break_control;

	assign port_enable = ctl_q[`ASU_CTL_PORT_EN];
	assign transmit_enable = ctl_q[`ASU_CTL_TX_EN];
	assign receive_enable = ctl_q[`ASU_CTL_RX_EN];
	assign infrared_enable = ctl_q[`ASU_CTL_IR_EN];
	assign infrared_low_power = ctl_q[`ASU_CTL_IR_LP];
	assign break_control = ctl_q[`ASU_CTL_BREAK];

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			ctl_q <= `ASU_CTL_RST;
			fmt_q <= `ASU_LCR_RST;
			baud_q <= `ASU_BAUD_RST;
		end
		else if (i_ce && i_wr)
		begin
			case (i_addr)
				`ASU_OFS_CTRL: ctl_q <= i_wdata[`ASU_CTL_W-1:0];
				`ASU_OFS_LCR: fmt_q <= i_wdata[`ASU_LCR_W-1:0];
				`ASU_OFS_BAUD: baud_q <= i_wdata[15:0];
				default: ;
			endcase
		end
	end

	// Flush once the character in flight is done
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			flush_q <= 1'b0;
		else if (i_ce)
			flush_q <= !port_enable && !transmit_enable && !tx_active; // RL17
	end

	assign rx_pop = i_ce && i_rd && (i_addr == `ASU_OFS_DATA) && rx_out_valid; // RL13

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			rdata_q <= '0;
		else if (i_ce)
		begin
			rdata_q <= '0;
			if (i_rd)
			begin
				case (i_addr)
					`ASU_OFS_DATA: rdata_q <= rx_out_valid ? 32'(rx_out_data) : `ASU_ST_RX_EMPTY_VAL;
					`ASU_OFS_STAT: rdata_q <= 32'({o_busy, tx_in_ready, rx_out_valid}); // RL15 RL16
					`ASU_OFS_CTRL: rdata_q <= 32'(ctl_q);
					`ASU_OFS_LCR: rdata_q <= 32'(fmt_q);
					`ASU_OFS_BAUD: rdata_q <= 32'(baud_q);
					default: rdata_q <= '0;
				endcase
			end
		end
	end
	assign o_rdata = rdata_q;

	// ****************************************************************
	// Queues
	// ****************************************************************
	asu_fifo #(.WIDTH(`ASU_TXW), .DEPTH(`ASU_FIFO_DEPTH)) u_txq ( // RL2
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_flush(flush_q),
		.i_in_valid(i_wr && (i_addr == `ASU_OFS_DATA)), // RL16
		.o_in_ready(tx_in_ready),
		.i_in_data(i_wdata[7:0]),
		.o_out_valid(tx_out_valid),
		.i_out_ready(tx_pop),
		.o_out_data(tx_out_data)
	);
	asu_fifo #(.WIDTH(`ASU_RXW), .DEPTH(`ASU_FIFO_DEPTH)) u_rxq ( // RL2
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_flush(1'b0),
		.i_in_valid(rx_push),
		.o_in_ready(rx_in_ready),
		.i_in_data(rx_word_d),
		.o_out_valid(rx_out_valid),
		.i_out_ready(rx_pop),
		.o_out_data(rx_out_data)
	);

	// ****************************************************************
	// Baud tick at sixteen times the bit rate
	// ****************************************************************
	// Divisor of zero stops the line entirely (DC)
	logic [15:0] div_q;
	logic tick;
	assign tick = (baud_q != '0) && (div_q == '0); // RL7
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			div_q <= '0;
		else if (i_ce)
			div_q <= (div_q == '0) ? baud_q - 1'b1 : div_q - 1'b1;
	end

	// Frame length in data bits minus one
	logic [2:0] nbits;
	assign nbits = 3'd4 + 3'(fmt_q.wlen); // RL4

	function automatic logic par_bit(input logic [7:0] d, input logic [2:0] nb, input asu_par_t p);
		logic x;
		x = 1'b0;
		for (int i = 0; i < 8; i++)
			if (3'(i) <= nb)
				x = x ^ d[i];
		case (p)
			EVEN_PAR: par_bit = x;
			ODD_PAR: par_bit = ~x;
			ONE_PAR: par_bit = 1'b1; // RL14
			ZERO_PAR: par_bit = 1'b0; // RL14
			default: par_bit = 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// Transmitter
	// ****************************************************************
	asu_state_t tst_q;
	logic [3:0] tovs_q;
	logic [2:0] tbit_q;
	logic [7:0] tsh_q;
	logic tline_q, tstop2_q;
	assign tx_active = (tst_q != S_IDLE);
	assign tx_pop = i_ce && tick && (tst_q == S_IDLE) && transmit_enable && port_enable;
	assign o_busy = tx_active || tx_out_valid; // RL11 RL12

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			tst_q <= S_IDLE;
			tovs_q <= '0;
			tbit_q <= '0;
			tsh_q <= '0;
			tline_q <= 1'b1;
			tstop2_q <= 1'b0;
		end
		else if (i_ce && tick)
		begin
			tovs_q <= tovs_q + 1'b1;
			case (tst_q)
				S_IDLE:
				begin
					tline_q <= 1'b1;
					tovs_q <= '0;
					if (tx_pop && tx_out_valid)
					begin
						tsh_q <= tx_out_data; // RL1
						tline_q <= 1'b0; // RL3
						tbit_q <= '0;
						tst_q <= S_START;
					end
				end
				S_START:
					if (tovs_q == `ASU_OVS_LAST)
					begin
						tline_q <= tsh_q[0];
						tst_q <= S_DATA;
					end
				S_DATA:
					if (tovs_q == `ASU_OVS_LAST)
					begin
						tbit_q <= tbit_q + 1'b1;
						tline_q <= tsh_q[3'(tbit_q + 1'b1)];
						if (tbit_q == nbits)
						begin
							tstop2_q <= fmt_q.stop2;
							if (fmt_q.par == NO_PAR)
							begin
								tline_q <= 1'b1;
								tst_q <= S_STOP;
							end
							else
							begin
								tline_q <= par_bit(tsh_q, nbits, fmt_q.par); // RL5
								tst_q <= S_PAR;
							end
						end
					end
				S_PAR:
					if (tovs_q == `ASU_OVS_LAST)
					begin
						tline_q <= 1'b1;
						tst_q <= S_STOP;
					end
				S_STOP:
					if (tovs_q == `ASU_OVS_LAST)
					begin
						if (tstop2_q) // RL6
							tstop2_q <= 1'b0;
						else
							tst_q <= S_IDLE; // RL12
					end
				default: tst_q <= S_IDLE;
			endcase
		end
	end

	// Infrared pulse: 3/8 bit, or a fixed short pulse in low power
	logic [7:0] irp_q;
	logic line_out;
	assign line_out = tline_q && !break_control; // RL8 RL9
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			irp_q <= '0;
		else if (i_ce)
		begin
			if (tick && tovs_q == '0 && !line_out)
				irp_q <= infrared_low_power ? `ASU_LP_PULSE : 8'(`ASU_IR_PULSE) * 8'(baud_q);
			else if (irp_q != '0)
				irp_q <= irp_q - 1'b1;
		end
	end
	assign o_tx = infrared_enable ? (irp_q != '0) : line_out; // RL10

	// ****************************************************************
	// Receiver
	// ****************************************************************
	logic rx_s1_q, rx_s2_q, rx_in, ir_hold_q;
	asu_state_t rst_q;
	logic [3:0] rovs_q;
	logic [2:0] rbit_q;
	logic [7:0] rsh_q;
	logic rpar_q, ovr_q;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			ir_hold_q <= 1'b1;
		end
		else if (i_ce)
		begin
			rx_s1_q <= i_rx;
			rx_s2_q <= rx_s1_q;
			// Infrared pulse holds a zero until the next tick in idle or the next sample at ASU_OVS_LAST
			if (rx_s2_q)
				ir_hold_q <= 1'b0;
			else if (tick && rst_q == S_IDLE)
				ir_hold_q <= 1'b1;
			else if (tick && rovs_q == `ASU_OVS_LAST)
				ir_hold_q <= 1'b1;
		end
	end
	assign rx_in = infrared_enable ? ir_hold_q : rx_s2_q; // RL10

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			rst_q <= S_IDLE;
			rovs_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			rpar_q <= 1'b0;
		end
		else if (i_ce && tick)
		begin
			rovs_q <= rovs_q + 1'b1;
			case (rst_q)
				S_IDLE:
				begin
					rovs_q <= '0;
					if (!rx_in && receive_enable && port_enable)
						rst_q <= S_START;
				end
				S_START:
					if (rovs_q == `ASU_OVS_MID) // RL19
					begin
						rovs_q <= '0;
						rbit_q <= '0;
						rsh_q <= '0;
						rst_q <= rx_in ? S_IDLE : S_DATA;
					end
				S_DATA:
					if (rovs_q == `ASU_OVS_LAST) // RL19
					begin
						rsh_q[rbit_q] <= rx_in; // RL3
						rbit_q <= rbit_q + 1'b1;
						if (rbit_q == nbits)
							rst_q <= (fmt_q.par == NO_PAR) ? S_STOP : S_PAR;
					end
				S_PAR:
					if (rovs_q == `ASU_OVS_LAST)
					begin
						rpar_q <= rx_in;
						rst_q <= S_STOP;
					end
				S_STOP:
					if (rovs_q == `ASU_OVS_LAST)
						rst_q <= S_IDLE;
				default: rst_q <= S_IDLE;
			endcase
		end
	end

	// Word handed to the queue at the stop sample
	always_comb
	begin
		rx_word_d.data = rsh_q;
		rx_word_d.frm_err = !rx_in; // RL18
		rx_word_d.par_err = (fmt_q.par != NO_PAR) && (rpar_q != par_bit(rsh_q, nbits, fmt_q.par)); // RL5 RL14
		rx_word_d.brk = !rx_in && (rsh_q == '0) && !rpar_q; // RL8
		rx_word_d.overrun = ovr_q; // RL18
	end
	// A full queue drops the character; overrun marks the next that fits
	assign rx_push = i_ce && tick && (rst_q == S_STOP) && (rovs_q == `ASU_OVS_LAST);
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			ovr_q <= 1'b0;
		else if (rx_push && !rx_in_ready)
			ovr_q <= 1'b1; // RL18
		else if (rx_push)
			ovr_q <= 1'b0;
	end
endmodule // asu_port

// ### rtl/asu_map.svh
// Register offsets, field positions and reset values of the serial port.
// Assumes inclusion by the package only; the port's design file uses its macros without including it.
`ifndef ASU_MAP_SVH
`define ASU_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ASU_OFS_DATA 4'h0
`define ASU_OFS_STAT 4'h1
`define ASU_OFS_CTRL 4'h2
`define ASU_OFS_LCR 4'h3
`define ASU_OFS_BAUD 4'h4

// ****************************************************************
// Control fields
// ****************************************************************
`define ASU_CTL_PORT_EN 0
`define ASU_CTL_TX_EN 1
`define ASU_CTL_RX_EN 2
`define ASU_CTL_IR_EN 3
`define ASU_CTL_IR_LP 4
`define ASU_CTL_BREAK 5
`define ASU_CTL_W 6
`define ASU_CTL_RST 6'h00

// ****************************************************************
// Line format fields
// ****************************************************************
`define ASU_LCR_WLEN_LO 0
`define ASU_LCR_WLEN_HI 1
`define ASU_LCR_PAR_LO 2
`define ASU_LCR_PAR_HI 4
`define ASU_LCR_STOP2 5
`define ASU_LCR_W 6
`define ASU_LCR_RST 6'h03

// ****************************************************************
// Status fields and constants
// ****************************************************************
`define ASU_ST_RX_AVAIL 0
`define ASU_ST_TX_ROOM 1
`define ASU_ST_BUSY 2
`define ASU_ST_RX_EMPTY_VAL 32'hFFFF_FFFF
`define ASU_BAUD_RST 16'h0001
`define ASU_OVS_LAST 4'hF
`define ASU_OVS_MID 4'h7
`define ASU_IR_PULSE 4'h6
`define ASU_LP_PULSE 8'h0A
`define ASU_FIFO_DEPTH 16
`define ASU_RXW 12
`define ASU_TXW 8

`endif

// ### rtl/asu_pkg.sv
// Types shared by the serial port and its queue.
// Assumes asu_map.svh sits on the include path.
`include "asu_map.svh"
package asu_pkg;
	typedef enum logic [2:0] {EVEN_PAR = 3'h0, ODD_PAR = 3'h1, ONE_PAR = 3'h2,
		ZERO_PAR = 3'h3, NO_PAR = 3'h4} asu_par_t;
	typedef struct packed {
		logic overrun;
		logic brk;
		logic par_err;
		logic frm_err;
		logic [7:0] data;
	} asu_rx_word_t;
	typedef struct packed {
		logic stop2;
		asu_par_t par;
		logic [1:0] wlen;
	} asu_fmt_t;
	typedef enum logic [4:0] {S_IDLE = 5'b00001, S_START = 5'b00010, S_DATA = 5'b00100,
		S_PAR = 5'b01000, S_STOP = 5'b10000} asu_state_t;
endpackage

// ### rtl/asu_fifo.sv
// Flip-flop queue with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset, clock enable.
`timescale 1ns/100ps
module asu_fifo
	import asu_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_q != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rp_q];

	always_ff @(posedge i_core_clk)
	begin
		if (i_ce && push)
			mem_q[wp_q] <= i_in_data;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n || (i_ce && i_flush))
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else if (i_ce)
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // asu_fifo

// ### sim/asu_port_assertions.sv
// Concurrent checks on the serial port's pins and register port.
// Assumes the baud divisor keeps its reset value of one.
`timescale 1ns/100ps
module asu_port_assertions
	import asu_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_rx,
	input wire logic o_tx,
	input wire logic o_busy
);
	logic [2:0] brk_q;
	logic [2:0] ir_q;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// ****
	// Control shadow, three cycles of history to cover output latency
	// ****
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			brk_q <= 3'h0;
			ir_q <= 3'h0;
		end
		else if (i_ce)
		begin
			brk_q <= {brk_q[1:0], (i_wr && i_addr == 4'h2) ? i_wdata[5] : brk_q[0]};
			ir_q <= {ir_q[1:0], (i_wr && i_addr == 4'h2) ? i_wdata[3] : ir_q[0]};
		end
	end
	// ****
	// Properties
	// ****
	a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_unmapped_read: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_stat_busy_bit: assert property (i_rd && i_addr == 4'h1 |=> o_rdata[2] == $past(o_busy))
		else $error("status busy bit differs from busy pin");
	a_busy_on_push: assert property (i_wr && i_addr == 4'h0 && !o_busy |=> o_busy)
		else $error("busy not raised by queued byte");
	a_low_means_busy: assert property (!o_tx && brk_q == 3'h0 && ir_q == 3'h0 |-> o_busy)
		else $error("line low while not busy");
	a_line_idle_high: assert property (!o_busy && brk_q == 3'h0 && ir_q == 3'h0 |-> o_tx)
		else $error("idle line not high");
	a_break_low: assert property (brk_q == 3'h7 |-> !o_tx)
		else $error("line not low during break");
	a_ir_idle_low: assert property (ir_q == 3'h7 && brk_q == 3'h0 && !o_busy |-> !o_tx)
		else $error("infrared idle line not low");
	a_start_len: assert property ($fell(o_tx) && brk_q == 3'h0 && ir_q == 3'h0 |-> !o_tx [*8])
		else $error("start bit too short");
	a_busy_after_stop: assert property ($fell(o_busy) && brk_q == 3'h0 && ir_q == 3'h0
		|-> $past(o_tx, 1) && $past(o_tx, 12))
		else $error("busy fell before stop bit ended");
	c_push: cover property (i_wr && i_addr == 4'h0);
	c_busy_end: cover property ($fell(o_busy));
	c_break: cover property (brk_q == 3'h7);
endmodule // asu_port_assertions

bind asu_port asu_port_assertions chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_rx(i_rx), .o_tx(o_tx), .o_busy(o_busy));

// ### sim/asu_remote.sv
// Far-end serial transceiver model: sends and captures frames.
// Assumes normal idle-high signalling and a fixed bit time.
`timescale 1ns/100ps
module asu_remote #(
	parameter int BIT_NS = 160
)(
	input wire logic i_line,
	output logic o_line
);
	initial o_line = 1'b1;
	function automatic logic par_bit(input logic [7:0] b, input int nb, input int pm);
		logic x;
		x = ^(b & (8'hFF >> (8 - nb)));
		case (pm)
			0: return x;
			1: return ~x;
			2: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	// ****
	// Sender, optional bad parity
	// ****
	task automatic send(input logic [7:0] b, input int nb, input int pm, input int st,
		input logic bad);
		o_line = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < nb; i++)
		begin
			o_line = b[i];
			#(BIT_NS);
		end
		if (pm < 4)
		begin
			o_line = par_bit(b, nb, pm) ^ bad;
			#(BIT_NS);
		end
		o_line = 1'b1;
		#(BIT_NS * st);
	endtask
	task automatic brk(input int nbits);
		o_line = 1'b0;
		#(BIT_NS * nbits);
		o_line = 1'b1;
		#(BIT_NS * 2);
	endtask
	// ****
	// Capture, mid-bit sampling
	// ****
	task automatic capture(input int nb, input int pm, input int st, output logic [7:0] d,
		output logic p, output logic s);
		d = 8'h00;
		p = 1'b0;
		s = 1'b1;
		@(negedge i_line);
		#(BIT_NS / 2);
		for (int i = 0; i < nb; i++)
		begin
			#(BIT_NS);
			d[i] = i_line;
		end
		if (pm < 4)
		begin
			#(BIT_NS);
			p = i_line;
		end
		for (int i = 0; i < st; i++)
		begin
			#(BIT_NS);
			s = s & i_line;
		end
	endtask
endmodule // asu_remote

// ### sim/test_asu_port.sv
// Self-checking bench for the serial port through its register port.
// Assumes baud divisor one: a bit lasts 16 clocks of 10 ns.
`timescale 1ns/100ps
module test_asu_port
	import asu_pkg::*;
;
	logic clk, rst_n, ce, wr, rd, rx, tx, busy, cap_p, cap_s;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [7:0] b, m, cap_d;
	int nb, pm, st, cycles;
	int n_errors = 0;
	int n_compared = 0;
	asu_port dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx(rx), .o_tx(tx),
		.o_busy(busy));
	asu_remote #(.BIT_NS(160)) remote_u (.i_line(tx), .o_line(rx));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic wait_idle;
		for (int k = 0; k < 4000 && busy !== 1'b0; k++)
			@(posedge clk);
	endtask
	task automatic complete_run;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cut a hang short well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_errors++;
			complete_run();
		end
	end
	// ****
	// Scenarios
	// ****
	initial
	begin
		cycles = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(4'h2, d); check(d, 32'h0);
		rd_reg(4'h3, d); check(d, 32'h3);
		rd_reg(4'h4, d); check(d, 32'h1);
		rd_reg(4'h1, d); check(d, 32'h2);
		rd_reg(4'h5, d); check(d, 32'h0);
		rd_reg(4'h0, d); check(d, 32'hFFFF_FFFF);
		wr_reg(4'h2, 32'h7);
		for (int f = 0; f < 20; f++)
		begin
			nb = f % 4 + 5;
			pm = f / 4;
			st = f % 2 + 1;
			b = 8'(f * 37 + 90);
			m = 8'hFF >> (8 - nb);
			wr_reg(4'h3, 32'(f % 4 + pm * 4 + (st - 1) * 32));
			wr_reg(4'h0, {24'h0, b});
			remote_u.capture(nb, pm, st, cap_d, cap_p, cap_s);
			check(cap_d, b & m);
			if (pm < 4)
				check(cap_p, remote_u.par_bit(b, nb, pm));
			check(cap_s, 1'b1);
			remote_u.send(b, nb, pm, st, 1'b0);
			repeat (20) @(posedge clk);
			rd_reg(4'h1, d); check(d[0], 1'b1);
			rd_reg(4'h0, d); check(d, {24'h0, b & m});
		end
		wr_reg(4'h3, 32'h3);
		remote_u.send(8'h5A, 8, 0, 1, 1'b1);
		repeat (20) @(posedge clk);
		rd_reg(4'h0, d); check(d, 32'h25A);
		remote_u.brk(22);
		repeat (40) @(posedge clk);
		rd_reg(4'h0, d); check(32'({d[10], d[7:0]}), 32'h100);
		wr_reg(4'h2, 32'h27);
		repeat (352) @(posedge clk);
		check(tx, 1'b0);
		wr_reg(4'h2, 32'h7);
		repeat (4) @(posedge clk);
		check(tx, 1'b1);
		// A long break leaves several characters queued
		for (int k = 0; k < 4; k++)
			rd_reg(4'h0, d);
		check(d, 32'hFFFF_FFFF);
		wr_reg(4'h2, 32'hF);
		repeat (4) @(posedge clk);
		check(tx, 1'b0);
		wr_reg(4'h2, 32'h7);
		wr_reg(4'h3, 32'h13);
		fork
			for (int i = 0; i < 17; i++)
			begin
				remote_u.capture(8, 4, 1, cap_d, cap_p, cap_s);
				check(cap_d, 8'(i + 16));
			end
		join_none
		for (int i = 0; i < 18; i++)
			wr_reg(4'h0, 32'(i + 16));
		rd_reg(4'h1, d); check(d, 32'h4);
		wait_idle();
		check(busy, 1'b0);
		for (int i = 0; i < 3; i++)
			wr_reg(4'h0, 32'h55);
		@(negedge tx);
		wr_reg(4'h2, 32'h0);
		wait_idle();
		rd_reg(4'h1, d); check(d, 32'h2);
		wr_reg(4'h2, 32'h7);
		repeat (300) @(posedge clk);
		check(busy, 1'b0);
		complete_run();
	end
endmodule // test_asu_port
